// ---- lmsg_cfg.svh ----
// Function
// (R01) scan lines run upward from line 0
// (R02) line count 6 to 11 sets lines scanned
// (R03) slot is active plus blank plus two shifts
// (R04) active time 8 us or 16 us
// (R05) blanking time 1 us or 0.5 us
// (R06) phase shift 0 or 125 ns
// (R07) sub-period is slot times line count
// (R08) optional sink turn-on delay after line on
// (R09) upside ghost: discharge and clamp during blank
// (R10) precharge all sinks in blank, downside strength
// (R11) compensation per group from three fields
// (R12) peak-current code maps to seven currents
// (R13) peak-current code resets to 011
// (R14) refresh mode 1 applies peak code at once
// (R15) modes 2,3: latch while disabled, apply on enable
// (R16) ghost settings follow peak-code update timing
// (R17) color gain is 7-bit code over 127
// (R18) sink index modulo three picks group
// (R19) three color gains, each reset to 64
// (R20) dot gain is 8 bits per dot
// (R21) gain storage for every dot of matrix
// (R22) current is peak times color times dot gain
// (R23) normal operation within 100 us of enable
// (R24) wrap to line 0 with no extra gap
// (R25) reserved code 111 keeps previous peak
// (R26) no scan line or sink enabled during blanking
`ifndef LMSG_CFG_SVH
`define LMSG_CFG_SVH
// clock period and printed times, picoseconds
`define LMSG_CLK_PS        4000
`define LMSG_T_PWM_FAST_PS 8000000
`define LMSG_T_PWM_SLOW_PS 16000000
`define LMSG_T_BLK_LONG_PS 1000000
`define LMSG_T_BLK_SHRT_PS 500000
`define LMSG_T_PHASE_PS    125000
`define LMSG_T_CSD_FAST_PS 31250
`define LMSG_T_CSD_SLOW_PS 62500
`define LMSG_T_READY_PS    100000000
// least times round up, longest round down
`define LMSG_CYC_UP(t) (((t)+`LMSG_CLK_PS-1)/`LMSG_CLK_PS)
`define LMSG_CYC_DN(t) ((t)/`LMSG_CLK_PS)
// reset values and codes
`define LMSG_PEAK_RST      3'h3
`define LMSG_PEAK_RSVD     3'h7
`define LMSG_COLOR_RST     7'h40
`define LMSG_DOT_RST       8'h80
`define LMSG_MODE_1        2'h1
`define LMSG_LINES_MIN     4'h6
`define LMSG_LINES_MAX     4'hb
// peak currents in tenths of a milliamp
`define LMSG_PEAK_0 10'h04b
`define LMSG_PEAK_1 10'h07d
`define LMSG_PEAK_2 10'h0fa
`define LMSG_PEAK_3 10'h177
`define LMSG_PEAK_4 10'h1f4
`define LMSG_PEAK_5 10'h2ee
`define LMSG_PEAK_6 10'h3e8
`endif

// ---- lmsg_pkg.sv ----
package lmsg_pkg;
	// scan sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACTIVE,
		ST_BLANK
	} lmsg_state_t;
	// de-ghost settings as applied to the analog side
	typedef struct packed {
		logic       up_en;   // scan line discharge and clamp
		logic [1:0] down;    // sink precharge strength
	} lmsg_ghost_t;
	// three color group gains
	typedef struct packed {
		logic [6:0] first;
		logic [6:0] second;
		logic [6:0] third;
	} lmsg_gain3_t;
	// one sink current result
	typedef struct packed {
		logic        valid;  // high for 18 cycles, one per sink
		logic [4:0]  sink;   // sink index
		logic [24:0] value;  // peak x color x dot
	} lmsg_cur_t;
endpackage : lmsg_pkg

// ---- lmsg_dot_ram.sv ----
`timescale 1ns/1ps
// dot gain store, one write port, registered read
module lmsg_dot_ram #(
	parameter int DEPTH = 198,
	parameter int AW    = 8,
	parameter int DW    = 8
)(
	input  wire logic          clk_sys,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);
	logic [DW-1:0] mem_ff [DEPTH];  // dot storage
	logic [DW-1:0] rd_data_ff;      // read register

	// refuse a depth the address cannot reach
	if (DEPTH > (1 << AW))
	begin : g_chk
		$error("dot ram depth exceeds address range");
	end

	// write and registered read
	always_ff @(posedge clk_sys)
	begin
		if (wr_en)
			mem_ff[wr_addr] <= wr_data;
		rd_data_ff <= mem_ff[rd_addr];
	end

	assign rd_data = rd_data_ff;
endmodule : lmsg_dot_ram

// ---- lmsg_scan.sv ----
`timescale 1ns/1ps
`include "lmsg_cfg.svh"
// matrix scan sequencer with analog gain handling
module lmsg_scan
	import lmsg_pkg::*;
#(
	parameter int LINES     = 11,
	parameter int SINKS     = 18,
	parameter int AW        = 8,
	parameter int READY_CYC = `LMSG_CYC_DN(`LMSG_T_READY_PS)
)(
	input  wire logic               clk_sys,
	input  wire logic               reset,
	input  wire logic               chip_en,
	input  wire logic [1:0]         refresh_mode,
	input  wire logic [3:0]         line_count,
	input  wire logic               pwm_slow_sel,
	input  wire logic               blanking_time_select,
	input  wire logic               phase_shift_en,
	input  wire logic               sink_on_shift,
	input  wire logic               up_deghost_en,
	input  wire logic [1:0]         down_deghost,
	input  wire logic [1:0]         low_level_comp_first,
	input  wire logic [1:0]         low_level_comp_second,
	input  wire logic [1:0]         low_level_comp_third,
	input  wire logic [2:0]         peak_current_code,
	input  wire logic [6:0]         color_gain_first,
	input  wire logic [6:0]         color_gain_second,
	input  wire logic [6:0]         color_gain_third,
	input  wire logic               dot_wr_en,
	input  wire logic [AW-1:0]      dot_wr_addr,
	input  wire logic [7:0]         dot_gain,
	output logic [LINES-1:0]        scan_line_on,
	output logic [SINKS-1:0]        sink_on,
	output logic [3:0]              line_index,
	output logic                    blanking,
	output logic                    scan_clamp_on,
	output logic                    sink_precharge_on,
	output lmsg_ghost_t             ghost_applied,
	output logic [SINKS-1:0][1:0]   sink_comp,
	output logic [2:0]              peak_applied,
	output lmsg_gain3_t             color_applied,
	output lmsg_cur_t               sink_current,
	output logic                    normal_ready,
	output logic                    dot_init_busy
);
	localparam int DOTS = LINES * SINKS;
	// slot timing in clock cycles
	localparam logic [12:0] PWM_F = 13'(`LMSG_CYC_UP(`LMSG_T_PWM_FAST_PS));
	localparam logic [12:0] PWM_S = 13'(`LMSG_CYC_UP(`LMSG_T_PWM_SLOW_PS));
	localparam logic [12:0] BLK_L = 13'(`LMSG_CYC_UP(`LMSG_T_BLK_LONG_PS));
	localparam logic [12:0] BLK_S = 13'(`LMSG_CYC_UP(`LMSG_T_BLK_SHRT_PS));
	localparam logic [12:0] PH    = 13'(`LMSG_CYC_UP(`LMSG_T_PHASE_PS));
	localparam logic [12:0] CSD_F = 13'(`LMSG_CYC_UP(`LMSG_T_CSD_FAST_PS));
	localparam logic [12:0] CSD_S = 13'(`LMSG_CYC_UP(`LMSG_T_CSD_SLOW_PS));

	// refuse shapes the sequencer cannot serve
	if (LINES != 11 || SINKS != 18 || DOTS > (1 << AW) || READY_CYC < 1
		|| READY_CYC > `LMSG_CYC_DN(`LMSG_T_READY_PS))
	begin : g_chk
		$error("lmsg_scan parameters out of range");
	end

	// peak code to tenths of a milliamp
	function automatic logic [9:0] peak_tenths(input logic [2:0] code);
		case (code)
			3'h0:    peak_tenths = `LMSG_PEAK_0; // R12
			3'h1:    peak_tenths = `LMSG_PEAK_1;
			3'h2:    peak_tenths = `LMSG_PEAK_2;
			3'h3:    peak_tenths = `LMSG_PEAK_3;
			3'h4:    peak_tenths = `LMSG_PEAK_4;
			3'h5:    peak_tenths = `LMSG_PEAK_5;
			default: peak_tenths = `LMSG_PEAK_6;
		endcase
	endfunction : peak_tenths

	// sequencer state
	lmsg_state_t       state_ff;         // scan phase
	logic [12:0]       cnt_ff;           // cycle within phase
	logic [3:0]        line_ff;          // current line
	logic [14:0]       rdy_cnt_ff;       // enable-to-ready count
	logic              ready_ff;         // normal operation
	logic              chip_en_d_ff;     // enable, one cycle late
	// update shadows
	logic [2:0]        peak_pend_ff;     // peak code held while off
	logic [2:0]        peak_app_ff;      // peak code in use
	lmsg_ghost_t       ghost_pend_ff;    // ghost held while off
	lmsg_ghost_t       ghost_app_ff;     // ghost in use
	lmsg_gain3_t       color_ff;         // color gains in use
	// dot memory initialisation
	logic              init_ff;          // sweep in progress
	logic [AW-1:0]     init_addr_ff;     // sweep address
	// output registers
	logic [LINES-1:0]  line_on_ff;
	logic [SINKS-1:0]  sink_on_ff;
	logic              blank_ff;
	logic              clamp_ff;
	logic              prech_ff;
	logic [SINKS-1:0][1:0] comp_ff;
	// current pipeline
	logic              rd_v_ff;          // read issued last cycle
	logic [4:0]        rd_idx_ff;        // its sink index
	lmsg_cur_t         cur_ff;           // product out

	// decoded selections
	wire logic [12:0] pwm_len = pwm_slow_sel ? PWM_S : PWM_F;     // R04
	wire logic [12:0] blk_len = blanking_time_select ? BLK_S
		: BLK_L;                                                  // R05
	wire logic [12:0] ph_len  = phase_shift_en ? PH : 13'h0;      // R06
	wire logic [12:0] act_len = pwm_len + 13'(ph_len << 1);       // R03
	wire logic [12:0] csd_len = !sink_on_shift ? 13'h0
		: (pwm_slow_sel ? CSD_S : CSD_F);                         // R08
	// line count clamped to the legal span
	wire logic [3:0]  lines_eff = (line_count < `LMSG_LINES_MIN)
		? `LMSG_LINES_MIN : (line_count > `LMSG_LINES_MAX)
		? `LMSG_LINES_MAX : line_count;                           // R02
	wire logic [3:0]  last_line = lines_eff - 4'h1;
	wire logic        in_act    = (state_ff == ST_ACTIVE);
	wire logic        in_blk    = (state_ff == ST_BLANK);
	wire logic        act_end   = in_act && (cnt_ff >= act_len - 13'h1);
	wire logic        blk_end   = in_blk && (cnt_ff >= blk_len - 13'h1);
	wire logic        en_rise   = chip_en && !chip_en_d_ff;
	wire logic        mode1     = (refresh_mode == `LMSG_MODE_1);
	wire logic        peak_ok   = (peak_current_code != `LMSG_PEAK_RSVD);
	wire lmsg_ghost_t ghost_in  = '{up_en: up_deghost_en,
		down: down_deghost};

	// per-group sink windows, staggered by the phase shift
	logic [2:0] grp_on;
	for (genvar g = 0; g < 3; g++)
	begin : g_grp
		wire logic [12:0] start = csd_len + 13'(ph_len * g);
		assign grp_on[g] = in_act && (cnt_ff >= start)
			&& (cnt_ff < start + pwm_len);                        // R08 R26
	end

	// next value of sink enables and compensation, by index mod 3
	logic [SINKS-1:0]      nxt_sink_on;
	logic [SINKS-1:0][1:0] nxt_comp;
	for (genvar s = 0; s < SINKS; s++)
	begin : g_sink
		assign nxt_sink_on[s] = grp_on[s % 3];                    // R18
		assign nxt_comp[s] = (s % 3 == 0) ? low_level_comp_first
			: (s % 3 == 1) ? low_level_comp_second
			: low_level_comp_third;                               // R11
	end

	// one-hot line drive, active phase only
	wire logic [LINES-1:0] nxt_line_on = in_act
		? LINES'(1) << line_ff : '0;                              // R01 R26
	wire logic [3:0] nxt_line = (line_ff >= last_line)
		? 4'h0 : line_ff + 4'h1;                                  // R24

	// dot memory ports
	wire logic          rd_go   = in_act && (cnt_ff < 13'(SINKS));
	wire logic [AW-1:0] rd_addr = AW'(line_ff * SINKS)
		+ AW'(cnt_ff[4:0]);                                       // R21
	wire logic          ram_we  = init_ff
		|| (dot_wr_en && (dot_wr_addr < AW'(DOTS)));
	wire logic [AW-1:0] ram_wa  = init_ff ? init_addr_ff : dot_wr_addr;
	wire logic [7:0]    ram_wd  = init_ff ? `LMSG_DOT_RST : dot_gain;
	logic [7:0] dot_rd;

	// selected color gain for the sink being read
	wire logic [6:0] cc_sel = (rd_idx_ff % 5'h3 == 5'h0)
		? color_ff.first : (rd_idx_ff % 5'h3 == 5'h1)
		? color_ff.second : color_ff.third;                       // R18
	wire logic [24:0] cur_prod = 25'(peak_tenths(peak_app_ff))
		* 25'(cc_sel) * 25'(dot_rd);                              // R22

	lmsg_dot_ram #(
		.DEPTH (DOTS),
		.AW    (AW),
		.DW    (8)
	) u_dot_ram (
		.clk_sys (clk_sys),
		.wr_en   (ram_we),
		.wr_addr (ram_wa),
		.wr_data (ram_wd),
		.rd_addr (rd_addr),
		.rd_data (dot_rd)
	);                                                            // R20

	// dot gain reset: sweep the store with the default
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			init_ff      <= 1'b1;
			init_addr_ff <= '0;
		end
		else if (init_ff)
		begin
			init_addr_ff <= init_addr_ff + AW'(1);
			// stop after the last dot
			if (init_addr_ff == AW'(DOTS - 1))
				init_ff <= 1'b0;                                  // R21
		end
	end

	// enable edge and ready timer
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			chip_en_d_ff <= 1'b0;
			rdy_cnt_ff   <= '0;
			ready_ff     <= 1'b0;
		end
		else
		begin
			chip_en_d_ff <= chip_en;
			// disable drops readiness at once
			if (!chip_en || init_ff)
			begin
				rdy_cnt_ff <= '0;
				ready_ff   <= 1'b0;
			end
			// count up to the ready point
			else if (!ready_ff)
			begin
				rdy_cnt_ff <= rdy_cnt_ff + 15'h1;
				if (rdy_cnt_ff == 15'(READY_CYC - 1))
					ready_ff <= 1'b1;                             // R23
			end
		end
	end

	// peak code and ghost settings by refresh mode
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			peak_pend_ff  <= `LMSG_PEAK_RST;                      // R13
			peak_app_ff   <= `LMSG_PEAK_RST;
			ghost_pend_ff <= '0;
			ghost_app_ff  <= '0;
		end
		// mode 1 takes new values immediately
		else if (mode1)
		begin
			if (peak_ok)
				peak_app_ff <= peak_current_code;                 // R14 R25
			ghost_app_ff <= ghost_in;                             // R16
		end
		// other modes latch while off, apply on enable
		else
		begin
			if (!chip_en && peak_ok)
				peak_pend_ff <= peak_current_code;                // R15 R25
			if (!chip_en)
				ghost_pend_ff <= ghost_in;                        // R16
			if (en_rise)
			begin
				peak_app_ff  <= peak_pend_ff;                     // R15
				ghost_app_ff <= ghost_pend_ff;                    // R16
			end
		end
	end

	// color gains, one field per group
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			color_ff <= '{default: `LMSG_COLOR_RST};              // R19
		else
			color_ff <= '{first: color_gain_first,
				second: color_gain_second,
				third: color_gain_third};                         // R17
	end

	// scan sequencer: active slot, blank, next line
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			state_ff <= ST_IDLE;
			cnt_ff   <= '0;
			line_ff  <= '0;
		end
		else
		begin
			case (state_ff)
				// wait for normal operation, start at line 0
				ST_IDLE:
				begin
					cnt_ff  <= '0;
					line_ff <= '0;                                // R01
					if (ready_ff)
						state_ff <= ST_ACTIVE;
				end
				// lines and sinks on for the active part
				ST_ACTIVE:
				begin
					if (!ready_ff)
						state_ff <= ST_IDLE;
					else if (act_end)
					begin
						state_ff <= ST_BLANK;                     // R03
						cnt_ff   <= '0;
					end
					else
						cnt_ff <= cnt_ff + 13'h1;
				end
				// blanking between slots
				ST_BLANK:
				begin
					if (!ready_ff)
						state_ff <= ST_IDLE;
					else if (blk_end)
					begin
						state_ff <= ST_ACTIVE;                    // R07 R24
						cnt_ff   <= '0;
						line_ff  <= nxt_line;                     // R01
					end
					else
						cnt_ff <= cnt_ff + 13'h1;
				end
				default:
				begin
					state_ff <= ST_IDLE;
					cnt_ff   <= '0;
				end
			endcase
		end
	end

	// drive registers for switches, sinks and blank helpers
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			line_on_ff <= '0;
			sink_on_ff <= '0;
			blank_ff   <= 1'b0;
			clamp_ff   <= 1'b0;
			prech_ff   <= 1'b0;
			comp_ff    <= '0;
		end
		else
		begin
			line_on_ff <= nxt_line_on;                            // R26
			sink_on_ff <= nxt_sink_on;
			blank_ff   <= in_blk;
			clamp_ff   <= in_blk && ghost_app_ff.up_en;           // R09
			prech_ff   <= in_blk;                                 // R10
			comp_ff    <= nxt_comp;
		end
	end

	// current pipeline: read dot gain, then multiply
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			rd_v_ff   <= 1'b0;
			rd_idx_ff <= '0;
			cur_ff    <= '0;
		end
		else
		begin
			rd_v_ff   <= rd_go;
			rd_idx_ff <= cnt_ff[4:0];
			cur_ff    <= '{valid: rd_v_ff, sink: rd_idx_ff,
				value: rd_v_ff ? cur_prod : 25'h0};               // R22
		end
	end

	// outputs straight from registers
	assign scan_line_on      = line_on_ff;
	assign sink_on           = sink_on_ff;
	assign line_index        = line_ff;
	assign blanking          = blank_ff;
	assign scan_clamp_on     = clamp_ff;
	assign sink_precharge_on = prech_ff;
	assign ghost_applied     = ghost_app_ff;                      // R10
	assign sink_comp         = comp_ff;
	assign peak_applied      = peak_app_ff;
	assign color_applied     = color_ff;
	assign sink_current      = cur_ff;
	assign normal_ready      = ready_ff;
	assign dot_init_busy     = init_ff;
endmodule : lmsg_scan

// ---- lmsg_scan_checker.sv ----
`timescale 1ns/1ps
// port-level rules of the scan sequencer
module lmsg_scan_checker
	import lmsg_pkg::*;
#(
	parameter int LINES = 11,
	parameter int SINKS = 18
)(
	input wire logic                  clk_sys,
	input wire logic                  reset,
	input wire logic                  chip_en,
	input wire logic [1:0]            refresh_mode,
	input wire logic [2:0]            peak_current_code,
	input wire logic [1:0]            low_level_comp_first,
	input wire logic [1:0]            low_level_comp_second,
	input wire logic [1:0]            low_level_comp_third,
	input wire logic [LINES-1:0]      scan_line_on,
	input wire logic [SINKS-1:0]      sink_on,
	input wire logic [3:0]            line_index,
	input wire logic                  blanking,
	input wire logic                  scan_clamp_on,
	input wire logic                  sink_precharge_on,
	input wire lmsg_ghost_t           ghost_applied,
	input wire logic [SINKS-1:0][1:0] sink_comp,
	input wire logic [2:0]            peak_applied,
	input wire logic                  normal_ready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// nothing lit in the gap between slots
	a_blank_dark:
	assert property (blanking |-> scan_line_on == '0 && sink_on == '0)
	else $error("line or sink on in blank");
	a_precharge_blank:
	assert property (sink_precharge_on == blanking)
	else $error("precharge not tied to blank");
	a_clamp_blank:
	assert property (scan_clamp_on == (blanking && ghost_applied.up_en))
	else $error("clamp wrong");
	a_peak_legal:
	assert property (peak_applied != 3'h7)
	else $error("reserved peak code applied");
	// immediate mode: code shows one cycle after it is taken
	a_mode1_peak:
	assert property ((refresh_mode == 2'h1 && peak_current_code != 3'h7)
		|=> peak_applied == $past(peak_current_code))
	else $error("peak code not applied");
	// latched modes: no change while enabled
	a_hold_enabled:
	assert property ((refresh_mode != 2'h1 && $past(refresh_mode) != 2'h1
		&& chip_en && $past(chip_en))
		|=> $stable(peak_applied) && $stable(ghost_applied))
	else $error("applied setting moved while enabled");
	a_line_step:
	assert property (($changed(line_index) && normal_ready) |->
		(line_index == $past(line_index) + 4'h1 || line_index == 4'h0))
	else $error("line order broken");
	a_line_range:
	assert property ($onehot0(scan_line_on) && line_index < 4'hb)
	else $error("line out of range");
	a_ready_drop:
	assert property (!chip_en |=> !normal_ready)
	else $error("ready while disabled");
	a_comp_map:
	assert property (1'b1 |=> sink_comp[15] == $past(low_level_comp_first)
		&& sink_comp[16] == $past(low_level_comp_second)
		&& sink_comp[17] == $past(low_level_comp_third))
	else $error("compensation group map wrong");
	a_sink_line:
	assert property (sink_on != '0 |-> scan_line_on != '0)
	else $error("sink on without line");
endmodule : lmsg_scan_checker

bind lmsg_scan lmsg_scan_checker #(.LINES(LINES), .SINKS(SINKS)) u_chk (
	.clk_sys, .reset, .chip_en, .refresh_mode, .peak_current_code,
	.low_level_comp_first, .low_level_comp_second, .low_level_comp_third,
	.scan_line_on, .sink_on, .line_index, .blanking, .scan_clamp_on,
	.sink_precharge_on, .ghost_applied, .sink_comp, .peak_applied,
	.normal_ready);

// ---- lmsg_matrix_model.sv ----
`timescale 1ns/1ps
// matrix side: measures line, blank and sink timing
module lmsg_matrix_model (
	input wire logic        clk_sys,
	input wire logic [10:0] scan_line_on,
	input wire logic [17:0] sink_on,
	input wire logic        blanking,
	output int              line_len,
	output int              blank_len,
	output int              sink_dly,
	output int              last_line,
	output int              line_cnt
);
	int          n_on;            // cycles current line is on
	int          n_blk;           // cycles of current blank
	logic [10:0] prev = 11'h000;  // line drive one cycle ago
	logic        ps2 = 1'b0;      // third-phase sink one cycle ago
	// count widths of line pulses and gaps
	always @(posedge clk_sys)
	begin
		prev <= scan_line_on;
		ps2 <= sink_on[2];
		if (scan_line_on != 11'h000)
			n_on <= (prev == 11'h000) ? 1 : n_on + 1;
		if (scan_line_on != 11'h000 && prev == 11'h000)
		begin
			line_cnt <= line_cnt + 1;
			for (int i = 0; i < 11; i++)
				if (scan_line_on[i])
					last_line <= i;
		end
		if (scan_line_on == 11'h000 && prev != 11'h000)
			line_len <= n_on;
		// sink turn-on offset from line start
		// a sink rising with the line counts as no delay
		if (sink_on[2] && !ps2)
			sink_dly <= (prev == 11'h000) ? 0 : n_on;
		if (blanking)
			n_blk <= n_blk + 1;
		else
		begin
			if (n_blk != 0)
				blank_len <= n_blk;
			n_blk <= 0;
		end
	end
endmodule : lmsg_matrix_model

// ---- lmsg_scan_tb_top.sv ----
`timescale 1ns/1ps
module lmsg_scan_tb_top;
	import lmsg_pkg::*;
	localparam int RDY = 20; // short enable wait
	localparam int MA10[7] = '{75, 125, 250, 375, 500, 750, 1000};
	logic clk_sys, reset, chip_en, pwm_slow_sel, blanking_time_select;
	logic phase_shift_en, sink_on_shift, up_deghost_en, dot_wr_en;
	logic normal_ready, dot_init_busy, blanking;
	logic scan_clamp_on, sink_precharge_on;
	logic [1:0] refresh_mode, down_deghost;
	logic [1:0] low_level_comp_first, low_level_comp_second;
	logic [1:0] low_level_comp_third;
	logic [3:0] line_count, line_index;
	logic [2:0] peak_current_code, peak_applied;
	logic [6:0] color_gain_first, color_gain_second, color_gain_third;
	logic [7:0] dot_wr_addr, dot_gain;
	logic [10:0] scan_line_on;
	logic [17:0] sink_on;
	logic [17:0][1:0] sink_comp;
	lmsg_ghost_t ghost_applied;
	lmsg_gain3_t color_applied;
	lmsg_cur_t sink_current;
	logic [24:0] v;
	int n_errors, check_count, line_len, blank_len, sink_dly;
	int last_line, line_cnt;
	lmsg_scan #(.READY_CYC(RDY)) u_lmsg_scan (.clk_sys, .reset, .chip_en,
		.refresh_mode, .line_count, .pwm_slow_sel, .blanking_time_select,
		.phase_shift_en, .sink_on_shift, .up_deghost_en, .down_deghost,
		.low_level_comp_first, .low_level_comp_second,
		.low_level_comp_third, .peak_current_code, .color_gain_first,
		.color_gain_second, .color_gain_third, .dot_wr_en, .dot_wr_addr,
		.dot_gain, .scan_line_on, .sink_on, .line_index, .blanking,
		.scan_clamp_on, .sink_precharge_on, .ghost_applied, .sink_comp,
		.peak_applied, .color_applied, .sink_current, .normal_ready,
		.dot_init_busy);
	lmsg_matrix_model u_lmsg_matrix_model (.clk_sys, .scan_line_on,
		.sink_on, .blanking, .line_len, .blank_len, .sink_dly, .last_line,
		.line_cnt);
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report;
		$display("Checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc
	// wait for n more line starts, bounded
	task automatic lines(input int n);
		int t;
		t = line_cnt + n;
		for (int i = 0; i < 9000 * n && line_cnt < t; i++)
			@(negedge clk_sys);
	endtask : lines
	// take the next line as reference, then expect n steps wrapping at n
	task automatic order(input int n);
		int r;
		lines(1);
		r = last_line;
		for (int k = 1; k <= n; k++)
		begin
			lines(1);
			check(last_line, (r + k) % n);
		end
	endtask : order
	// capture a current result for sink s, on line 0 if l0
	task automatic cur(input logic [4:0] s, input logic l0);
		v = 'x;
		for (int i = 0; i < 40000; i++)
		begin
			@(negedge clk_sys);
			if (sink_current.valid === 1'b1 && sink_current.sink === s
				&& (!l0 || line_index === 4'h0))
			begin
				v = sink_current.value;
				return;
			end
		end
	endtask : cur
	// enable and wait for ready, bounded
	task automatic enable;
		chip_en = 1'b1;
		for (int i = 0; i < RDY + 5 && normal_ready !== 1'b1; i++)
			cyc(1);
		check(normal_ready, 1'b1);
	endtask : enable
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial
	begin
		// about 100k cycles, above the longest expected run
		#400000;
		n_errors++;
		final_report;
	end
	initial
	begin
		reset = 1'b1; chip_en = 1'b0; refresh_mode = 2'h1;
		line_count = 4'h6; pwm_slow_sel = 1'b0;
		blanking_time_select = 1'b0; phase_shift_en = 1'b0;
		sink_on_shift = 1'b0; up_deghost_en = 1'b0; down_deghost = 2'h0;
		low_level_comp_first = 2'h0; low_level_comp_second = 2'h0;
		low_level_comp_third = 2'h0; peak_current_code = 3'h3;
		color_gain_first = 7'h40; color_gain_second = 7'h40;
		color_gain_third = 7'h40; dot_wr_en = 1'b0;
		dot_wr_addr = 8'h00; dot_gain = 8'h00;
		cyc(2);
		check(peak_applied, 3'h3);
		check(color_applied, {7'h40, 7'h40, 7'h40});
		reset = 1'b0;
		for (int i = 0; i < 300 && dot_init_busy !== 1'b0; i++)
			cyc(1);
		check(dot_init_busy, 1'b0);
		// basic scan: six lines, fast, long blank
		enable();
		order(6);
		check(line_len, 2000);
		check(blank_len, 250);
		check(sink_dly, 0);
		$display("test scan order done");
		// every peak code, current at default gains
		for (int c = 0; c < 7; c++)
		begin
			peak_current_code = c[2:0];
			cyc(2);
			check(peak_applied, c);
			cur(5'h01, 1'b0);
			check(v, MA10[c] * 64 * 128);
		end
		peak_current_code = 3'h7;
		cyc(2);
		check(peak_applied, 3'h6);
		$display("test peak codes done");
		// dot gain on line 0 sink 1, full color gain
		dot_wr_addr = 8'h01; dot_gain = 8'hff; dot_wr_en = 1'b1;
		color_gain_second = 7'h7f;
		cyc(1);
		dot_wr_en = 1'b0;
		cur(5'h01, 1'b1);
		check(v, 1000 * 127 * 255);
		color_gain_second = 7'h40;
		low_level_comp_first = 2'h1; low_level_comp_second = 2'h2;
		low_level_comp_third = 2'h3;
		cyc(2);
		check(sink_comp[15], 2'h1);
		check(sink_comp[16], 2'h2);
		check(sink_comp[17], 2'h3);
		$display("test gains done");
		// latched mode: held while on, applied on re-enable
		refresh_mode = 2'h2; peak_current_code = 3'h1;
		up_deghost_en = 1'b1; down_deghost = 2'h2;
		cyc(3);
		check(peak_applied, 3'h6);
		check(ghost_applied, 3'b0_00);
		chip_en = 1'b0;
		cyc(2);
		enable();
		check(peak_applied, 3'h1);
		check(ghost_applied, 3'b1_10);
		for (int i = 0; i < 9000 && blanking !== 1'b1; i++)
			cyc(1);
		check(scan_clamp_on, 1'b1);
		check(sink_precharge_on, 1'b1);
		$display("test latched mode done");
		// slow, short blank, phase shift, sink delay
		pwm_slow_sel = 1'b1; blanking_time_select = 1'b1;
		phase_shift_en = 1'b1; sink_on_shift = 1'b1;
		lines(3);
		check(line_len, 4064);
		check(blank_len, 125);
		check(sink_dly, 80);
		$display("test slow timing done");
		// over-range count scans all eleven lines
		pwm_slow_sel = 1'b0; blanking_time_select = 1'b0;
		phase_shift_en = 1'b0; sink_on_shift = 1'b0;
		line_count = 4'hf;
		order(11);
		$display("test eleven lines done");
		final_report;
	end
endmodule : lmsg_scan_tb_top
